// File: design/aws_pkg.sv
// Shared constants and state types of the sleep/wake sequencer
`default_nettype none

package aws_pkg;

  // Control port: 7-bit address, 0x9c as the write byte
  localparam logic [6:0] I2C_ADDR      = 7'h4e;

  // Register offsets
  localparam logic [6:0] REG_SLEEP     = 7'h02;
  localparam logic [6:0] REG_GPIO1     = 7'h21;
  localparam logic [6:0] REG_GPO1      = 7'h22;
  localparam logic [6:0] REG_GPI       = 7'h2b;
  localparam logic [6:0] REG_CH1_SRC   = 7'h3c;
  localparam logic [6:0] REG_CH2_SRC   = 7'h41;
  localparam logic [6:0] REG_CH_EN     = 7'h73;
  localparam logic [6:0] REG_SLOT_EN   = 7'h74;
  localparam logic [6:0] REG_PWR       = 7'h75;
  localparam logic [6:0] REG_STATUS    = 7'h77;
  localparam logic [7:0] REG_RST       = 8'h00;

  // Field positions and codes
  localparam int         SLEEP_WAKE_BIT  = 0;
  localparam int         SLEEP_ANALOG_REGULATOR_BIT  = 7;
  localparam int         PWR_BIAS_BIT    = 7;
  localparam int         PWR_ADC_BIT     = 6;
  localparam int         PWR_PLL_BIT     = 5;
  localparam int         SRC_LSB         = 5;
  localparam logic [1:0] SRC_DIGITAL     = 2'h2;
  localparam int         GPO_CFG_LSB     = 4;
  localparam logic [3:0] GPO_PDM_CLOCK_OUT      = 4'h4;
  localparam int         GPI1_CFG_LSB    = 4;
  localparam int         GPI2_CFG_LSB    = 0;
  localparam logic [2:0] GPI_PDMDATA     = 3'h4;

  // Timing
  localparam int unsigned MCLK_KHZ     = 125000;
  localparam int unsigned INIT_MS      = 1;
  localparam int unsigned WAKE_MS      = 1;
  localparam int unsigned RAMP_MS      = 6;
  localparam int unsigned INIT_CYC     = INIT_MS * MCLK_KHZ;
  localparam int unsigned WAKE_CYC     = WAKE_MS * MCLK_KHZ;
  localparam int unsigned RAMP_CYC     = RAMP_MS * MCLK_KHZ;
  localparam int          TIMER_W      = 20;
  localparam logic [3:0]  ATTEN_MAX    = 4'hf;
  localparam int unsigned ATTEN_STEPS  = 16;
  localparam logic [5:0]  PDM_HALF     = 6'h14;
  localparam logic [5:0]  PDM_WIN      = 6'h3f;

  // Control port states
  typedef enum logic [8:0] {
    I_IDLE = 9'h001, I_ADDR = 9'h002, I_AACK = 9'h004,
    I_REG  = 9'h008, I_RACK = 9'h010, I_DATA = 9'h020,
    I_DACK = 9'h040, I_READ = 9'h080, I_MACK = 9'h100
  } aws_i2c_type;

  // Power sequence states
  typedef enum logic [5:0] {
    P_INIT   = 6'h01, P_SLEEP = 6'h02, P_WAKE  = 6'h04,
    P_ACTIVE = 6'h08, P_RAMP  = 6'h10, P_DRAIN = 6'h20
  } aws_pwr_type;

endpackage

`default_nettype wire

// File: design/aws_tdm_tx.sv
// TDM slot transmitter running on the link bit clock
`default_nettype none

module aws_tdm_tx import aws_pkg::*; (
  // Link clock and reset
  input  wire logic        bitClk,
  input  wire logic        nrst,
  // Audio serial bus
  input  wire logic        frameSync,
  output logic             dataOut,
  output logic             dataOe,
  // To and from the control domain
  input  wire logic        txEnable,
  input  wire logic        sampleToggle,
  input  wire logic [63:0] sampleWord,
  input  wire logic [3:0]  slotMask,
  output logic             txBusy
);

  typedef struct packed {
    logic        enMeta;
    logic        enSync;
    logic        tglMeta;
    logic        tglSync;
    logic        tglPrev;
    logic        fsPrev;
    logic        inFrame;
    logic [6:0]  bitCnt;
    logic [63:0] word;
    logic [3:0]  mask;
    logic        dout;
    logic        doe;
  } aws_tx_type;

  aws_tx_type r;
  aws_tx_type n;
  logic       fsRise;
  logic       frameOn;
  logic [6:0] cnt;
  logic       drive;

  // Slot n carries channel n+1 as a 16-bit word, MSB first, then zeros
  function automatic logic slotBit(input logic [63:0] w,
                                   input logic [6:0] c);
    return (c[4] == 1'b0) ? w[{c[6:5], 4'hf - c[3:0]}] : 1'b0;
  endfunction

  assign fsRise  = frameSync & ~r.fsPrev;
  assign frameOn = fsRise | (r.inFrame & (r.bitCnt != 7'h7f));
  assign cnt     = fsRise ? 7'h00 : 7'(r.bitCnt + 7'h01);
  assign drive   = r.enSync & frameOn & r.mask[cnt[6:5]];

  always_comb begin
    n = r;
    n.enMeta  = txEnable;
    n.enSync  = r.enMeta;
    n.tglMeta = sampleToggle;
    n.tglSync = r.tglMeta;
    n.tglPrev = r.tglSync;
    n.fsPrev  = frameSync;
    // Words are held still between toggles, so a late capture is safe
    if (r.tglSync != r.tglPrev) begin
      n.word = sampleWord;
      n.mask = slotMask;
    end
    if (fsRise) begin
      n.inFrame = 1'b1;
      n.bitCnt  = 7'h00;
    end else if (r.inFrame) begin
      n.bitCnt = cnt;
      if (r.bitCnt == 7'h7f) begin
        n.inFrame = 1'b0;
      end
    end
    n.doe  = drive;
    n.dout = drive & slotBit(r.word, cnt);
  end

  always_ff @(posedge bitClk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dataOut = r.dout;
  assign dataOe  = r.doe;
  assign txBusy  = r.enSync;

  txIdle_a: assert property (@(posedge bitClk) disable iff (!nrst)
    !r.enSync |=> (!dataOe && !dataOut))
    else $error("bus driven while transmitter disabled");

  slotGate_a: assert property (@(posedge bitClk) disable iff (!nrst)
    (frameOn && !r.mask[cnt[6:5]]) |=> !dataOe)
    else $error("disabled slot driven");

  slotData_a: assert property (@(posedge bitClk) disable iff (!nrst)
    drive |=> (dataOe && dataOut == $past(slotBit(r.word, cnt))))
    else $error("slot bit does not match captured sample");

endmodule // aws_tdm_tx

`default_nettype wire

// File: design/aws_sleep_wake_seq.sv
// Power sequencer, control port, PDM capture and channel gating
`default_nettype none

module aws_sleep_wake_seq import aws_pkg::*; #(
  parameter int unsigned INIT_CYCLES = INIT_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned RAMP_CYCLES = RAMP_CYC
) (
  // System
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Control port pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Audio serial interface
  input  wire logic        bitClk,
  input  wire logic        frameSync,
  output logic             asiDataOut,
  output logic             asiDataOe,
  // Converter core
  input  wire logic [15:0] analogSample1,
  input  wire logic [15:0] analogSample2,
  output logic             analogRegEn,
  output logic             adcPowerEn,
  output logic             micBiasEn,
  output logic             pllPowerEn,
  // PDM microphones
  input  wire logic        pdmDataIn1,
  input  wire logic        pdmDataIn2,
  output logic             pdmClockOut1,
  output logic             pdmClockOut2
);

  localparam int unsigned RAMP_STEP = RAMP_CYCLES / ATTEN_STEPS;

  typedef struct packed {
    logic                   sclMeta;
    logic                   sclSync;
    logic                   sclPrev;
    logic                   sdaMeta;
    logic                   sdaSync;
    logic                   sdaPrev;
    logic                   pdm1Meta;
    logic                   pdm1Sync;
    logic                   pdm2Meta;
    logic                   pdm2Sync;
    logic                   ackMeta;
    logic                   ackSync;
    aws_i2c_type            i2c;
    logic [3:0]             bitCnt;
    logic [7:0]             shift;
    logic [6:0]             ptr;
    logic                   rw;
    logic                   sdaOe;
    logic [127:0][7:0]      regs;
    aws_pwr_type            pwr;
    logic [TIMER_W-1:0]     timer;
    logic [3:0]             atten;
    logic [5:0]             divCnt;
    logic                   pdm_clock_out;
    logic [5:0]             winCnt;
    logic [3:0][6:0]        acc;
    logic [3:0][15:0]       samples;
    logic [3:0]             slotMask;
    logic                   toggle;
    logic                   txEn;
    logic                   aregEn;
    logic                   adcEn;
    logic                   biasEn;
    logic                   pllEn;
    logic                   pdmOut1;
    logic                   pdmOut2;
  } aws_main_type;

  aws_main_type r;
  aws_main_type n;
  logic         sclRise;
  logic         sclFall;
  logic         startCond;
  logic         stopCond;
  logic         wakeBit;
  logic         live;
  logic [7:0]   statusView;
  logic [7:0]   pwrReg;
  logic [7:0]   gpiReg;
  logic         pdm1On;
  logic         pdm2On;
  logic         winEnd;
  logic [3:0]   dig;
  logic         txBusy;

  // Register read view; status is live state, not storage
  function automatic logic [7:0] readReg(input logic [127:0][7:0] regs,
                                         input logic [6:0] ptr,
                                         input logic [7:0] status);
    return (ptr == REG_STATUS) ? status : regs[ptr];
  endfunction

  // Ones density over a window, full density maps to zero
  function automatic logic [15:0] pdmToPcm(input logic [6:0] ones);
    return 16'({1'b0, ones, 8'h00} - 16'h4000);
  endfunction

  function automatic logic [15:0] chSample(input logic        isDig,
                                           input logic [6:0]  ones,
                                           input logic [15:0] ana,
                                           input logic        en,
                                           input logic [3:0]  att);
    logic signed [15:0] raw;
    raw = isDig ? pdmToPcm(ones) : ana;
    return en ? 16'(raw >>> att) : 16'h0000;
  endfunction

  assign sclRise    = r.sclSync & ~r.sclPrev;
  assign sclFall    = ~r.sclSync & r.sclPrev;
  assign startCond  = r.sclSync & r.sdaPrev & ~r.sdaSync;
  assign stopCond   = r.sclSync & ~r.sdaPrev & r.sdaSync;
  assign wakeBit    = r.regs[REG_SLEEP][SLEEP_WAKE_BIT];
  assign live       = (r.pwr == P_ACTIVE) || (r.pwr == P_RAMP);
  assign statusView = {r.pwr == P_SLEEP, live, r.adcEn, 5'h00};
  assign pwrReg     = r.regs[REG_PWR];
  assign gpiReg     = r.regs[REG_GPI];
  assign pdm1On     = gpiReg[GPI1_CFG_LSB +: 3] == GPI_PDMDATA;
  assign pdm2On     = gpiReg[GPI2_CFG_LSB +: 3] == GPI_PDMDATA;
  assign winEnd     = r.adcEn && r.divCnt == PDM_HALF - 6'h01 &&
                      r.pdm_clock_out && r.winCnt == PDM_WIN;
  // Channels 3 and 4 exist only as PDM inputs
  assign dig = {2'b11,
                r.regs[REG_CH2_SRC][SRC_LSB +: 2] == SRC_DIGITAL,
                r.regs[REG_CH1_SRC][SRC_LSB +: 2] == SRC_DIGITAL};

  always_comb begin
    n = r;
    n.sclMeta  = sclIn;
    n.sclSync  = r.sclMeta;
    n.sclPrev  = r.sclSync;
    n.sdaMeta  = sdaIn;
    n.sdaSync  = r.sdaMeta;
    n.sdaPrev  = r.sdaSync;
    n.pdm1Meta = pdmDataIn1;
    n.pdm1Sync = r.pdm1Meta;
    n.pdm2Meta = pdmDataIn2;
    n.pdm2Sync = r.pdm2Meta;
    n.ackMeta  = txBusy;
    n.ackSync  = r.ackMeta;

    // Control port: register byte, then data bytes, auto-increment
    if (sclRise && (r.i2c == I_ADDR || r.i2c == I_REG ||
                    r.i2c == I_DATA || r.i2c == I_READ)) begin
      n.bitCnt = 4'(r.bitCnt + 4'h1);
      if (r.i2c != I_READ) begin
        n.shift = {r.shift[6:0], r.sdaSync};
      end
    end
    if (sclRise && r.i2c == I_MACK) begin
      n.rw = ~r.sdaSync;
    end
    if (startCond) begin
      n.i2c    = I_ADDR;
      n.bitCnt = 4'h0;
      n.sdaOe  = 1'b0;
    end else if (stopCond) begin
      n.i2c   = I_IDLE;
      n.sdaOe = 1'b0;
    end else if (sclFall) begin
      case (r.i2c)
        I_ADDR: begin
          if (r.bitCnt == 4'h8) begin
            // Unmatched address or still initializing: no acknowledge
            if (r.shift[7:1] == I2C_ADDR && r.pwr != P_INIT) begin
              n.i2c   = I_AACK;
              n.rw    = r.shift[0];
              n.sdaOe = 1'b1;
            end else begin
              n.i2c = I_IDLE;
            end
          end
        end
        I_AACK: begin
          n.bitCnt = 4'h0;
          if (r.rw) begin
            n.i2c   = I_READ;
            n.shift = readReg(r.regs, r.ptr, statusView);
            n.sdaOe = ~n.shift[7];
          end else begin
            n.i2c   = I_REG;
            n.sdaOe = 1'b0;
          end
        end
        I_REG: begin
          if (r.bitCnt == 4'h8) begin
            n.ptr   = r.shift[6:0];
            n.i2c   = I_RACK;
            n.sdaOe = 1'b1;
          end
        end
        I_RACK, I_DACK: begin
          n.i2c    = I_DATA;
          n.bitCnt = 4'h0;
          n.sdaOe  = 1'b0;
        end
        I_DATA: begin
          if (r.bitCnt == 4'h8) begin
            if (r.ptr != REG_STATUS) begin
              n.regs[r.ptr] = r.shift;
            end
            n.ptr   = 7'(r.ptr + 7'h01);
            n.i2c   = I_DACK;
            n.sdaOe = 1'b1;
          end
        end
        I_READ: begin
          if (r.bitCnt == 4'h8) begin
            n.i2c   = I_MACK;
            n.sdaOe = 1'b0;
          end else begin
            n.shift = {r.shift[6:0], 1'b0};
            n.sdaOe = ~r.shift[6];
          end
        end
        I_MACK: begin
          if (r.rw) begin
            n.ptr    = 7'(r.ptr + 7'h01);
            n.shift  = readReg(r.regs, n.ptr, statusView);
            n.sdaOe  = ~n.shift[7];
            n.bitCnt = 4'h0;
            n.i2c    = I_READ;
          end else begin
            n.i2c = I_IDLE;
          end
        end
        I_IDLE: begin
          n.i2c = I_IDLE;
        end
        default: begin
          n.i2c   = I_IDLE;
          n.sdaOe = 1'b0;
        end
      endcase
    end

    // Power sequence; register storage is never cleared here
    n.timer = TIMER_W'(r.timer + 1'b1);
    case (r.pwr)
      P_INIT: begin
        if (r.timer == TIMER_W'(INIT_CYCLES - 1)) begin
          n.pwr = P_SLEEP;
        end
      end
      P_SLEEP: begin
        n.timer = '0;
        n.atten = 4'h0;
        if (wakeBit) begin
          n.pwr = P_WAKE;
        end
      end
      P_WAKE: begin
        if (!wakeBit) begin
          n.pwr = P_SLEEP;
        end else if (r.timer == TIMER_W'(WAKE_CYCLES - 1)) begin
          n.pwr = P_ACTIVE;
        end
      end
      P_ACTIVE: begin
        n.timer = '0;
        if (!wakeBit) begin
          n.pwr = P_RAMP;
        end
      end
      P_RAMP: begin
        // A wake during ramp-down waits for the sleep to complete
        if (r.timer == TIMER_W'(RAMP_STEP - 1)) begin
          n.timer = '0;
          n.atten = 4'(r.atten + 4'h1);
          if (r.atten == ATTEN_MAX) begin
            n.pwr = P_DRAIN;
          end
        end
      end
      P_DRAIN: begin
        // Status must not claim sleep while a slot can still go out
        if (!r.ackSync) begin
          n.pwr = P_SLEEP;
        end
      end
      default: begin
        n.pwr = P_INIT;
      end
    endcase

    n.adcEn  = ((n.pwr == P_ACTIVE) || (n.pwr == P_RAMP)) &&
               pwrReg[PWR_ADC_BIT];
    n.pllEn  = ((n.pwr == P_ACTIVE) || (n.pwr == P_RAMP)) &&
               pwrReg[PWR_PLL_BIT];
    n.biasEn = ((n.pwr == P_ACTIVE) || (n.pwr == P_RAMP)) &&
               pwrReg[PWR_BIAS_BIT];
    n.aregEn = (n.pwr != P_INIT) && (n.pwr != P_SLEEP) &&
               r.regs[REG_SLEEP][SLEEP_ANALOG_REGULATOR_BIT];
    n.txEn   = n.adcEn;

    // PDM clock and capture; pin 1 feeds ch1/ch2, pin 2 feeds ch3/ch4
    if (!r.adcEn) begin
      n.divCnt = 6'h00;
      n.pdm_clock_out = 1'b0;
      n.winCnt = 6'h00;
      n.acc    = '0;
    end else if (r.divCnt == PDM_HALF - 6'h01) begin
      n.divCnt = 6'h00;
      n.pdm_clock_out = ~r.pdm_clock_out;
      if (!r.pdm_clock_out) begin
        n.acc[0] = 7'(r.acc[0] + (r.pdm1Sync & pdm1On));
        n.acc[2] = 7'(r.acc[2] + (r.pdm2Sync & pdm2On));
      end else begin
        n.acc[1] = 7'(r.acc[1] + (r.pdm1Sync & pdm1On));
        n.acc[3] = 7'(r.acc[3] + (r.pdm2Sync & pdm2On));
        n.winCnt = 6'(r.winCnt + 6'h01);
      end
    end else begin
      n.divCnt = 6'(r.divCnt + 6'h01);
    end
    if (winEnd) begin
      for (int i = 0; i < 4; i++) begin
        // Next-state count keeps the last falling-edge bit of ch2/ch4
        n.samples[i] = chSample(dig[i], n.acc[i],
                                (i == 0) ? analogSample1 :
                                (i == 1) ? analogSample2 : 16'h0000,
                                r.regs[REG_CH_EN][7 - i],
                                r.atten);
        n.slotMask[i] = r.regs[REG_SLOT_EN][7 - i];
      end
      n.toggle = ~r.toggle;
      n.acc    = '0;
    end
    n.pdmOut1 = n.pdm_clock_out &&
                r.regs[REG_GPO1][GPO_CFG_LSB +: 4] == GPO_PDM_CLOCK_OUT;
    n.pdmOut2 = n.pdm_clock_out &&
                r.regs[REG_GPIO1][GPO_CFG_LSB +: 4] == GPO_PDM_CLOCK_OUT;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r         <= '0;
      r.i2c     <= I_IDLE;
      r.pwr     <= P_INIT;
      r.sclMeta <= 1'b1;
      r.sclSync <= 1'b1;
      r.sclPrev <= 1'b1;
      r.sdaMeta <= 1'b1;
      r.sdaSync <= 1'b1;
      r.sdaPrev <= 1'b1;
    end else begin
      r <= n;
    end
  end

  aws_tdm_tx u_tx (
    .bitClk       (bitClk),
    .nrst         (nrst),
    .frameSync    (frameSync),
    .dataOut      (asiDataOut),
    .dataOe       (asiDataOe),
    .txEnable     (r.txEn),
    .sampleToggle (r.toggle),
    .sampleWord   (r.samples),
    .slotMask     (r.slotMask),
    .txBusy       (txBusy)
  );

  assign sdaOut       = 1'b0 & r.sdaOe;
  assign sdaOe        = r.sdaOe;
  assign analogRegEn  = r.aregEn;
  assign adcPowerEn   = r.adcEn;
  assign micBiasEn    = r.biasEn;
  assign pllPowerEn   = r.pllEn;
  assign pdmClockOut1 = r.pdmOut1;
  assign pdmClockOut2 = r.pdmOut2;

  initSleep_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_INIT && r.timer == TIMER_W'(INIT_CYCLES - 1))
      |=> (r.pwr == P_SLEEP && !adcPowerEn && !r.txEn))
    else $error("initialization did not end asleep");

  wakeStart_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_SLEEP && wakeBit) |=> r.pwr == P_WAKE ##1
      (r.pwr == P_WAKE || !wakeBit))
    else $error("wake write did not start wake-up");

  rampEntry_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_ACTIVE && !wakeBit) |=> (r.pwr == P_RAMP && r.atten == 4'h0))
    else $error("sleep write did not start ramp-down");

  sleepQuiet_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_SLEEP) |-> (!adcPowerEn && !micBiasEn && !pllPowerEn &&
                            !r.ackSync))
    else $error("blocks powered or bus busy while asleep");

  sleepFlag_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_DRAIN && !r.ackSync) |=> statusView[7] && !statusView[6])
    else $error("sleep status bit not set after shutdown");

  retain_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_DRAIN) |=> $stable(r.regs[REG_CH_EN]) &&
                           $stable(r.regs[REG_PWR]))
    else $error("register content lost during sleep entry");

  chMask_a: assert property (@(posedge mclk) disable iff (!nrst)
    (winEnd && !r.regs[REG_CH_EN][7]) |=> r.samples[0] == 16'h0000)
    else $error("disabled channel recorded");

  addrNack_a: assert property (@(posedge mclk) disable iff (!nrst)
    (sclFall && !startCond && !stopCond && r.i2c == I_ADDR &&
     r.bitCnt == 4'h8 && r.shift[7:1] != I2C_ADDR)
      |=> (!sdaOe && r.i2c == I_IDLE))
    else $error("foreign address acknowledged");

  aregOn_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_ACTIVE && $past(r.pwr) == P_ACTIVE &&
     r.regs[REG_SLEEP] == 8'h81) |-> analogRegEn)
    else $error("regulator off after 0x81 wake");

  biasOff_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.pwr == P_ACTIVE && $past(r.pwr) == P_ACTIVE && pwrReg == 8'h60 &&
     $past(pwrReg) == 8'h60) |-> (adcPowerEn && pllPowerEn && !micBiasEn))
    else $error("0x60 power setting not applied");

  pdmClkGate_a: assert property (@(posedge mclk) disable iff (!nrst)
    (r.regs[REG_GPO1][GPO_CFG_LSB +: 4] != GPO_PDM_CLOCK_OUT) |=> !pdmClockOut1)
    else $error("PDM clock driven on unconfigured pin");

endmodule // aws_sleep_wake_seq

`default_nettype wire

// File: tb/aws_host_clk.sv
// Host model: link bit clock and frame sync source
`default_nettype none
module aws_host_clk (
  // Control from the bench
  input  wire logic run,
  // Link
  output logic      bitClk,
  output logic      frameSync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bitCnt = 8'h00;
  initial bitClk = 1'b0;
  initial frameSync = 1'b0;
  // Stands still between runs; stopped only after sleep is seen
  always begin
    if (run) begin
      #80 bitClk = 1'b1;
      #80 bitClk = 1'b0;
    end else begin
      #37;
    end
  end
  // 256 bits a frame, sync high for one bit
  always @(negedge bitClk) begin
    bitCnt <= bitCnt + 8'h01;
    frameSync <= (bitCnt == 8'hff);
  end
endmodule // aws_host_clk
`default_nettype wire

// File: tb/aws_sleep_wake_seq_tb.sv
// Self-checking bench of the sleep/wake sequencer
`default_nettype none
module aws_sleep_wake_seq_tb;
  import aws_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, nrst = 1'b0, scl = 1'b1, sdaDrv = 1'b1, run = 1'b0;
  logic [15:0] smp1 = 16'h0000, smp2 = 16'h0000;
  logic pdm1 = 1'b0, pdm2 = 1'b0;
  logic sdaOut, sdaOe, bitClk, frameSync, dOut, dOe;
  logic analog_regulator, adc, bias, pll, pclk1, pclk2;
  wire logic sdaW;
  int numErrors = 0, nTests = 0;
  logic [31:0] seed = 32'hba9b;
  logic [8:0] rx;
  logic [127:0] q;
  assign sdaW = sdaOe ? 1'b0 : sdaDrv;
  always #4 mclk = ~mclk;
  aws_host_clk host (.run(run), .bitClk(bitClk), .frameSync(frameSync));
  aws_sleep_wake_seq #(.INIT_CYCLES(64), .WAKE_CYCLES(64),
    .RAMP_CYCLES(256)) dut (.mclk(mclk), .nrst(nrst), .sclIn(scl),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .bitClk(bitClk),
    .frameSync(frameSync), .asiDataOut(dOut), .asiDataOe(dOe),
    .analogSample1(smp1), .analogSample2(smp2), .analogRegEn(analog_regulator),
    .adcPowerEn(adc), .micBiasEn(bias), .pllPowerEn(pll),
    .pdmDataIn1(pdm1), .pdmDataIn2(pdm2), .pdmClockOut1(pclk1),
    .pdmClockOut2(pclk2));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [127:0] tdm(input logic [15:0] c1, c2, c3, c4);
    return {c1, 16'h0000, c2, 16'h0000, c3, 16'h0000, c4, 16'h0000};
  endfunction
  // Ones count of a PDM window mapped to a sample, full window at zero
  function automatic logic [15:0] pcm(input int k);
    return 16'(k * 256 - 16384);
  endfunction
  task automatic chk(input string nm, input logic [127:0] e, g);
    nTests++;
    if (e !== g) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    if (numErrors == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bound(input logic ok);
    chk("bounded wait", 1'b1, ok);
    if (ok !== 1'b1) print_verdict();
  endtask
  // SCL half period of 10 mclk keeps clear of the 8 mclk minimum
  task automatic hp;
    repeat (10) @(posedge mclk);
  endtask
  task automatic st;
    hp();
    sdaDrv <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sdaDrv <= 1'b0;
    hp();
    scl <= 1'b0;
  endtask
  task automatic sp;
    hp();
    sdaDrv <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sdaDrv <= 1'b1;
    hp();
  endtask
  // Eight bits then the ninth with SDA released; rx[0] is the ack
  task automatic xb(input logic [7:0] b);
    logic [8:0] w;
    w = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      hp();
      sdaDrv <= w[i];
      hp();
      scl <= 1'b1;
      hp();
      rx[i] = sdaW;
      scl <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [2:0] ak;
    st();
    xb(8'h9c);
    ak[2] = rx[0];
    xb(a);
    ak[1] = rx[0];
    xb(d);
    ak[0] = rx[0];
    sp();
    chk("write ack", 3'h0, ak);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    st();
    xb(8'h9c);
    xb(a);
    st();
    xb(8'h9d);
    xb(8'hff);
    d = rx[8:1];
    sp();
  endtask
  // Skips early syncs, as one may be left high by a stopped clock
  task automatic frame(input logic [3:0] m, input logic [127:0] e);
    int k;
    for (k = 0; k < 600; k++) begin
      @(posedge bitClk);
      if (frameSync && k > 3) break;
    end
    bound(frameSync);
    for (int i = 0; i < 128; i++) begin
      @(negedge bitClk);
      q = {q[126:0], dOut};
      chk("slot enable", m[3 - i / 32], dOe);
    end
    chk("tdm data", e, q);
  endtask
  initial begin
    logic [7:0] v;
    logic [15:0] a1;
    int n;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (80) @(posedge mclk);
    chk("asleep", 6'h00, {analog_regulator, adc, bias, pll, dOe, sdaOut});
    wr(8'h77, 8'hff);
    rd(8'h77, v);
    chk("status", 8'h80, v);
    st();
    xb(8'h9e);
    v[0] = rx[0];
    sp();
    chk("foreign nack", 1'b1, v[0]);
    seed = xs(seed);
    wr(8'h30, seed[7:0]);
    rd(8'h30, v);
    chk("coef", seed[7:0], v);
    wr(8'h02, 8'h81);
    repeat (80) @(posedge mclk);
    chk("regulator", 1'b1, analog_regulator);
    seed = xs(seed);
    a1 = seed[15:0];
    smp1 <= a1;
    smp2 <= seed[31:16];
    wr(8'h73, 8'h80);
    wr(8'h74, 8'he0);
    wr(8'h75, 8'he0);
    chk("power e0", 3'h7, {adc, bias, pll});
    wr(8'h22, 8'h40);
    wr(8'h21, 8'h40);
    @(negedge mclk);
    v[1:0] = {pclk1, pclk2};
    repeat (20) @(negedge mclk);
    chk("pdm clock", v[1:0] ^ 2'h3, {pclk1, pclk2});
    run <= 1'b1;
    repeat (6000) @(posedge mclk);
    frame(4'he, tdm(a1, 16'h0000, 16'h0000, 16'h0000));
    wr(8'h75, 8'h60);
    chk("power 60", 3'h5, {adc, bias, pll});
    wr(8'h02, 8'h80);
    v = 8'h00;
    for (n = 0; n < 20 && v[7] !== 1'b1; n++) rd(8'h77, v);
    bound(v[7]);
    chk("sleep status", 8'h80, v);
    run <= 1'b0;
    repeat (100) @(posedge mclk);
    chk("powered off", 4'h0, {adc, analog_regulator, dOe, bias});
    rd(8'h73, v);
    chk("retained", 8'h80, v);
    wr(8'h02, 8'h01);
    repeat (80) @(posedge mclk);
    chk("rewake", 3'h4, {adc, bias, analog_regulator});
    wr(8'h3c, 8'h40);
    wr(8'h2b, 8'h44);
    wr(8'h73, 8'hf0);
    wr(8'h74, 8'hf0);
    pdm2 <= 1'b1;
    run <= 1'b1;
    repeat (6000) @(posedge mclk);
    frame(4'hf, tdm(pcm(0), smp2, pcm(64), pcm(64)));
    print_verdict();
  end
endmodule // aws_sleep_wake_seq_tb
`default_nettype wire
